/* File: logic/counter_latch_compare.sv */
// Purpose: per-axis capture, counter stop and compare logic
// Assumes: one clock, classic Wishbone slave, pins asynchronous
// Notes:   counter inputs arrive as up/down count enables
//
// Design decisions made here: the Wishbone slave port and the address map.
module counter_latch_compare (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // trigger pins
  input  wire logic        latch_pin,
  input  wire logic        origin_pin,
  input  wire logic        encoder_index_pin,
  input  wire logic [3:0]  general_pin,
  // count sources
  input  wire logic        cmd_pulse_in,
  input  wire logic        cmd_pulse_dir,
  input  wire logic        enc_step,
  input  wire logic        enc_dir,
  // outputs
  output logic             cmd_pulse_out,
  output logic             cmp_one_out_pin,
  output logic             cmp_two_out_pin,
  output logic             event_irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] latch_trigger_config;
  logic [31:0] counter_environment;
  logic [31:0] operation_mode_preset;
  logic [31:0] input_environment;
  logic [31:0] output_environment;
  logic [31:0] event_irq_enable;
  logic [31:0] event_flags;
  logic [31:0] counter_one;
  logic [31:0] counter_two;
  logic [31:0] compare_value_one;
  logic [31:0] compare_value_two;
  logic [31:0] third_capture_reg;
  logic [31:0] fourth_capture_reg;
  logic [31:0] extended_status;
  capcmp_pkg::cap_flags_s cap3_flags;
  capcmp_pkg::cap_flags_s cap4_flags;
  logic        cap3_hit;
  logic        cap4_hit;
  logic        bus_req;
  logic        wr_en;
  logic [7:0]  cmd_code;
  logic        cmd_wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic cmp_met(input logic [1:0]  cond,
                                   input logic [31:0] cv,
                                   input logic [31:0] cnt);
    logic r;
    r = 1'b0;
    unique case (cond)
      capcmp_pkg::CMP_OFF: r = 1'b0;
      capcmp_pkg::CMP_EQ:  r = (cv == cnt);
      capcmp_pkg::CMP_GT:  r = ($signed(cv) > $signed(cnt));
      capcmp_pkg::CMP_LT:  r = ($signed(cv) < $signed(cnt));
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change taken once stages two and three agree
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_s3;
  logic [6:0] pin_clean;
  logic [7:0] trig_pins;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_s1    <= '0;
      pin_s2    <= '0;
      pin_s3    <= '0;
      pin_clean <= '0;
    end else begin
      pin_s1 <= {general_pin, encoder_index_pin, origin_pin, latch_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 7; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_clean[i] <= pin_s3[i];
        end
      end
    end
  end

  assign trig_pins = {pin_clean, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // ack one cycle after the request; writes land on the ack edge only
  assign bus_req  = cyc_i && stb_i && !ack_o;
  assign wr_en    = cyc_i && stb_i && we_i && ack_o;
  assign cmd_wr   = wr_en && (adr_i == capcmp_pkg::OFS_COMMAND) && sel_i[0];
  assign cmd_code = dat_i[7:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_o <= 1'b0;
      dat_o <= capcmp_pkg::RESET_WORD;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        unique case (adr_i)
          capcmp_pkg::OFS_LATCH_CFG:   dat_o <= latch_trigger_config;
          capcmp_pkg::OFS_STATUS:      dat_o <= extended_status;
          capcmp_pkg::OFS_COUNTER_ENV: dat_o <= counter_environment;
          capcmp_pkg::OFS_OPMODE:      dat_o <= operation_mode_preset;
          capcmp_pkg::OFS_INPUT_ENV:   dat_o <= input_environment;
          capcmp_pkg::OFS_OUTPUT_ENV:  dat_o <= output_environment;
          capcmp_pkg::OFS_IRQ_EN:      dat_o <= event_irq_enable;
          capcmp_pkg::OFS_EVENT_FLAGS: dat_o <= event_flags;
          capcmp_pkg::OFS_COUNTER_ONE: dat_o <= counter_one;
          capcmp_pkg::OFS_COUNTER_TWO: dat_o <= counter_two;
          capcmp_pkg::OFS_CMP_ONE:     dat_o <= compare_value_one;
          capcmp_pkg::OFS_CMP_TWO:     dat_o <= compare_value_two;
          capcmp_pkg::OFS_CAP3:        dat_o <= third_capture_reg;
          capcmp_pkg::OFS_CAP4:        dat_o <= fourth_capture_reg;
          default:                     dat_o <= capcmp_pkg::RESET_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_trigger_config  <= capcmp_pkg::RESET_WORD;
      counter_environment   <= capcmp_pkg::RESET_WORD;
      operation_mode_preset <= capcmp_pkg::RESET_WORD;
      input_environment     <= capcmp_pkg::RESET_WORD;
      output_environment    <= capcmp_pkg::RESET_WORD;
      event_irq_enable      <= capcmp_pkg::RESET_WORD;
      compare_value_one     <= capcmp_pkg::RESET_WORD;
      compare_value_two     <= capcmp_pkg::RESET_WORD;
    end else if (wr_en) begin
      unique case (adr_i)
        capcmp_pkg::OFS_LATCH_CFG: latch_trigger_config <=
          merge(latch_trigger_config, dat_i, sel_i);
        capcmp_pkg::OFS_COUNTER_ENV: counter_environment <=
          merge(counter_environment, dat_i, sel_i);
        capcmp_pkg::OFS_OPMODE: operation_mode_preset <=
          merge(operation_mode_preset, dat_i, sel_i);
        capcmp_pkg::OFS_INPUT_ENV: input_environment <=
          merge(input_environment, dat_i, sel_i);
        capcmp_pkg::OFS_OUTPUT_ENV: output_environment <=
          merge(output_environment, dat_i, sel_i);
        capcmp_pkg::OFS_IRQ_EN: event_irq_enable <=
          merge(event_irq_enable, dat_i, sel_i);
        capcmp_pkg::OFS_CMP_ONE: compare_value_one <=
          merge(compare_value_one, dat_i, sel_i);
        capcmp_pkg::OFS_CMP_TWO: compare_value_two <=
          merge(compare_value_two, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters
  logic timer_mode;
  logic cmd_cnt_ok;
  logic enc_cnt_ok;
  logic step_one;
  logic step_two;
  logic dir_one;
  logic dir_two;

  assign timer_mode = operation_mode_preset[7:0] == capcmp_pkg::MODE_TIMER;
  // command source stops on inhibit or timer mode, not on output mask
  assign cmd_cnt_ok = cmd_pulse_in
                      && !operation_mode_preset[capcmp_pkg::OM_CMD_INH]
                      && !timer_mode;
  assign enc_cnt_ok = enc_step
                      && !input_environment[capcmp_pkg::IE_ENC_OFF];

  always_comb begin
    step_one = counter_environment[capcmp_pkg::CE_C1_SRC] ? enc_cnt_ok
                                                         : cmd_cnt_ok;
    dir_one  = counter_environment[capcmp_pkg::CE_C1_SRC] ? enc_dir
                                                         : cmd_pulse_dir;
    step_two = counter_environment[capcmp_pkg::CE_C2_SRC] ? enc_cnt_ok
                                                         : cmd_cnt_ok;
    dir_two  = counter_environment[capcmp_pkg::CE_C2_SRC] ? enc_dir
                                                         : cmd_pulse_dir;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      counter_one <= capcmp_pkg::RESET_WORD;
    end else if (wr_en && adr_i == capcmp_pkg::OFS_COUNTER_ONE) begin
      counter_one <= merge(counter_one, dat_i, sel_i);
    end else if (step_one
                 && !counter_environment[capcmp_pkg::CE_C1_HOLD]) begin
      counter_one <= dir_one ? counter_one - 32'h0000_0001
                             : counter_one + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      counter_two <= capcmp_pkg::RESET_WORD;
    end else if (wr_en && adr_i == capcmp_pkg::OFS_COUNTER_TWO) begin
      counter_two <= merge(counter_two, dat_i, sel_i);
    end else if (step_two
                 && !counter_environment[capcmp_pkg::CE_C2_HOLD]) begin
      counter_two <= dir_two ? counter_two - 32'h0000_0001
                             : counter_two + 32'h0000_0001;
    end
  end

  // pulse mask gates the pin only, counting is unaffected
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_pulse_out <= 1'b0;
    end else begin
      cmd_pulse_out <= cmd_pulse_in
                       && !output_environment[capcmp_pkg::OE_PULSE_MSK];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture channels
  capture_channel u_cap3 (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .cfg       (latch_trigger_config[7:0]),
    .begin_cmd (cmd_wr && cmd_code == capcmp_pkg::CMD_CAP3_BEGIN),
    .end_cmd   (cmd_wr && cmd_code == capcmp_pkg::CMD_CAP3_END),
    .pins      (trig_pins),
    .count_one (counter_one),
    .count_two (counter_two),
    .value     (third_capture_reg),
    .flags     (cap3_flags),
    .captured  (cap3_hit)
  );

  capture_channel u_cap4 (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .cfg       (latch_trigger_config[15:8]),
    .begin_cmd (cmd_wr && cmd_code == capcmp_pkg::CMD_CAP4_BEGIN),
    .end_cmd   (cmd_wr && cmd_code == capcmp_pkg::CMD_CAP4_END),
    .pins      (trig_pins),
    .count_one (counter_one),
    .count_two (counter_two),
    .value     (fourth_capture_reg),
    .flags     (cap4_flags),
    .captured  (cap4_hit)
  );

  always_comb begin
    extended_status = capcmp_pkg::RESET_WORD;
    extended_status[capcmp_pkg::ST_CAP3_MON]  = cap3_flags.monitoring;
    extended_status[capcmp_pkg::ST_CAP3_ONCE] = cap3_flags.once;
    extended_status[capcmp_pkg::ST_CAP3_TOG]  = cap3_flags.toggle;
    extended_status[capcmp_pkg::ST_CAP4_MON]  = cap4_flags.monitoring;
    extended_status[capcmp_pkg::ST_CAP4_ONCE] = cap4_flags.once;
    extended_status[capcmp_pkg::ST_CAP4_TOG]  = cap4_flags.toggle;
  end

  ////////////////////////////////////////////////////////////////////////
  // comparators and event flags
  logic cmp_one_met;
  logic cmp_two_met;
  logic [31:0] event_set;

  assign cmp_one_met = cmp_met(counter_environment[13:12],
                               compare_value_one, counter_one);
  assign cmp_two_met = cmp_met(counter_environment[15:14],
                               compare_value_two, counter_two);

  always_comb begin
    event_set = capcmp_pkg::RESET_WORD;
    event_set[capcmp_pkg::IRQ_CMP1] = cmp_one_met;
    event_set[capcmp_pkg::IRQ_CMP2] = cmp_two_met;
    event_set[capcmp_pkg::IRQ_CAP3] = cap3_hit;
    event_set[capcmp_pkg::IRQ_CAP4] = cap4_hit;
    event_set = event_set & event_irq_enable;
  end

  // write-one-to-clear, a new event in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      event_flags <= capcmp_pkg::RESET_WORD;
    end else if (wr_en && adr_i == capcmp_pkg::OFS_EVENT_FLAGS) begin
      event_flags <= (event_flags & ~(dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}})) | event_set;
    end else begin
      event_flags <= event_flags | event_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmp_one_out_pin <= 1'b0;
      cmp_two_out_pin <= 1'b0;
      event_irq       <= 1'b0;
    end else begin
      cmp_one_out_pin <= cmp_one_met;
      cmp_two_out_pin <= cmp_two_met;
      event_irq       <= |(event_flags | event_set);
    end
  end

  a_cmp_pin_follow: assert property (@(posedge clk_sys) disable iff (srst)
    cmp_one_met |=> cmp_one_out_pin)
    else $error("comparator one pin did not follow match");

  a_cap_event_set: assert property (@(posedge clk_sys) disable iff (srst)
    (cap3_hit && event_irq_enable[capcmp_pkg::IRQ_CAP3])
      |=> event_flags[capcmp_pkg::IRQ_CAP3] ##0 event_irq)
    else $error("capture event flag not set");

  a_hold_freeze: assert property (@(posedge clk_sys) disable iff (srst)
    (counter_environment[capcmp_pkg::CE_C1_HOLD]
      && !(wr_en && adr_i == capcmp_pkg::OFS_COUNTER_ONE))
      |=> counter_one == $past(counter_one))
    else $error("held counter one changed");

  a_timer_stop: assert property (@(posedge clk_sys) disable iff (srst)
    (timer_mode && !counter_environment[capcmp_pkg::CE_C2_SRC] && !wr_en)
      |=> counter_two == $past(counter_two))
    else $error("command count in timer mode");

endmodule

/* File: logic/capcmp_pkg.sv */
// Purpose: shared constants and carriers for the capture/compare block
// Assumes: 200 MHz clk_sys, classic Wishbone register access
// Notes:   register word offsets are byte addresses
package capcmp_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_COMMAND     = 8'h00;
  localparam logic [7:0] OFS_LATCH_CFG   = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_COUNTER_ENV = 8'h0C;
  localparam logic [7:0] OFS_OPMODE      = 8'h10;
  localparam logic [7:0] OFS_INPUT_ENV   = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_ENV  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN      = 8'h1C;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h20;
  localparam logic [7:0] OFS_COUNTER_ONE = 8'h24;
  localparam logic [7:0] OFS_COUNTER_TWO = 8'h28;
  localparam logic [7:0] OFS_CMP_ONE     = 8'h2C;
  localparam logic [7:0] OFS_CMP_TWO     = 8'h30;
  localparam logic [7:0] OFS_CAP3        = 8'h34;
  localparam logic [7:0] OFS_CAP4        = 8'h38;

  // command codes and timer mode code
  localparam logic [7:0] CMD_CAP3_BEGIN = 8'h3C;
  localparam logic [7:0] CMD_CAP4_BEGIN = 8'h3D;
  localparam logic [7:0] CMD_CAP3_END   = 8'h3E;
  localparam logic [7:0] CMD_CAP4_END   = 8'h3F;
  localparam logic [7:0] MODE_TIMER     = 8'h47;

  // latch config field positions (fourth latch at +8)
  localparam int CAP_SRC_LSB  = 0;
  localparam int CAP_EDGE_BIT = 3;
  localparam int CAP_CSEL_BIT = 4;
  localparam int CAP_MODE_BIT = 5;
  localparam int CAP_FLT_LSB  = 6;
  localparam int CAP4_SHIFT   = 8;

  // status bit positions
  localparam int ST_CAP3_MON = 17;
  localparam int ST_CAP3_ONCE = 18;
  localparam int ST_CAP3_TOG = 19;
  localparam int ST_CAP4_MON = 20;
  localparam int ST_CAP4_ONCE = 21;
  localparam int ST_CAP4_TOG = 22;

  // counter environment / mode / input / output / event bits
  localparam int CE_C1_HOLD   = 2;
  localparam int CE_C2_HOLD   = 3;
  localparam int CE_C1S_LSB   = 12;
  localparam int CE_C2S_LSB   = 14;
  localparam int CE_C1_SRC    = 16;
  localparam int CE_C2_SRC    = 17;
  localparam int OM_CMD_INH   = 11;
  localparam int IE_ENC_OFF   = 14;
  localparam int OE_PULSE_MSK = 31;
  localparam int IRQ_CMP1     = 6;
  localparam int IRQ_CMP2     = 7;
  localparam int IRQ_CAP3     = 16;
  localparam int IRQ_CAP4     = 17;

  // comparator condition codes
  localparam logic [1:0] CMP_OFF = 2'b00;
  localparam logic [1:0] CMP_EQ  = 2'b01;
  localparam logic [1:0] CMP_GT  = 2'b10;
  localparam logic [1:0] CMP_LT  = 2'b11;

  // filter widths at 200 MHz
  localparam int CLK_MHZ      = 200;
  localparam int FLT0_NS      = 100;
  localparam int FLT1_NS      = 3200;
  localparam int FLT2_NS      = 25000;
  localparam int FLT3_NS      = 200000;
  localparam int FLT0_CYC     = (FLT0_NS * CLK_MHZ + 999) / 1000;
  localparam int FLT1_CYC     = (FLT1_NS * CLK_MHZ + 999) / 1000;
  localparam int FLT2_CYC     = (FLT2_NS * CLK_MHZ + 999) / 1000;
  localparam int FLT3_CYC     = (FLT3_NS * CLK_MHZ + 999) / 1000;
  localparam int FLT_W        = 16;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] filter;
    logic       every;
    logic       csel;
    logic       edge_rise;
    logic [2:0] source;
  } cap_cfg_s;

  typedef struct packed {
    logic       monitoring;
    logic       once;
    logic       toggle;
  } cap_flags_s;

endpackage

/* File: logic/capture_channel.sv */
// Purpose: one trigger capture channel: select, filter, edge, latch
// Assumes: trigger pins already synchronised to clk_sys
// Notes:   filter counts stable cycles before the new level is accepted
module capture_channel (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // control
  input  wire capcmp_pkg::cap_cfg_s   cfg,
  input  wire logic                   begin_cmd,
  input  wire logic                   end_cmd,
  input  wire logic [7:0]             pins,
  input  wire logic [31:0]            count_one,
  input  wire logic [31:0]            count_two,
  // results
  output logic [31:0]                 value,
  output capcmp_pkg::cap_flags_s      flags,
  output logic                        captured
);

  logic                               raw;
  logic                               level;
  logic [capcmp_pkg::FLT_W-1:0]       stable;
  logic [capcmp_pkg::FLT_W-1:0]       need;
  logic                               edge_hit;

  always_comb begin
    raw = pins[cfg.source];
    unique case (cfg.filter)
      2'b00: need = capcmp_pkg::FLT_W'(capcmp_pkg::FLT0_CYC);
      2'b01: need = capcmp_pkg::FLT_W'(capcmp_pkg::FLT1_CYC);
      2'b10: need = capcmp_pkg::FLT_W'(capcmp_pkg::FLT2_CYC);
      2'b11: need = capcmp_pkg::FLT_W'(capcmp_pkg::FLT3_CYC);
    endcase
  end

  // pulse must hold its new level for the chosen width
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level  <= 1'b0;
      stable <= '0;
    end else if (raw == level) begin
      stable <= '0;
    end else if (stable + 1'b1 >= need) begin
      level  <= raw;
      stable <= '0;
    end else begin
      stable <= stable + 1'b1;
    end
  end

  // source 000 disables capture; edge picks the level entering
  assign edge_hit = (cfg.source != 3'b000) && (raw != level)
                    && (stable + 1'b1 >= need)
                    && (raw == cfg.edge_rise);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags    <= '0;
      value    <= capcmp_pkg::RESET_WORD;
      captured <= 1'b0;
    end else begin
      captured <= 1'b0;
      if (end_cmd) begin
        flags <= '0;
      end else if (begin_cmd) begin
        flags.monitoring <= 1'b1;
      end else if (flags.monitoring && edge_hit
                   && (cfg.every || !flags.once)) begin
        value         <= cfg.csel ? count_two : count_one;
        flags.once    <= 1'b1;
        flags.toggle  <= ~flags.toggle;
        captured      <= 1'b1;
      end
    end
  end

  a_end_clears: assert property (@(posedge clk_sys) disable iff (srst)
    end_cmd |=> (flags == '0))
    else $error("end command did not clear flags");

  a_idle_no_cap: assert property (@(posedge clk_sys) disable iff (srst)
    !flags.monitoring |=> !captured)
    else $error("capture while not monitoring");

  a_one_shot: assert property (@(posedge clk_sys) disable iff (srst)
    (flags.once && !cfg.every && !end_cmd && !begin_cmd) |=> !captured)
    else $error("second capture in first-trigger mode");

  a_toggle_step: assert property (@(posedge clk_sys) disable iff (srst)
    captured |-> (flags.toggle != $past(flags.toggle)) && flags.once)
    else $error("toggle flag did not follow capture");

endmodule

/* File: tb/trig_model.sv */
// Purpose: external trigger pin model
// Assumes: pins idle low and change just after clk_sys edges
// Notes:   a pulse inverts one pin for a set number of cycles
module trig_model (
  // clock
  input  wire logic       clk_sys,
  // trigger pins
  output logic      [6:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = 7'h00;
  task automatic pulse(input int idx, input int w);
    @(posedge clk_sys) pins[idx] <= ~pins[idx];
    repeat (w) @(posedge clk_sys);
    pins[idx] <= ~pins[idx];
  endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: register-level test of the capture/compare block
// Assumes: pulses of 40 cycles clear the shortest filter setting
// Notes:   counters step on command pulses or encoder steps
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cmd = 1'b0, enc = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic        ack_o, pulse_out, cmp1, cmp2, irq;
  logic [6:0]  pins;
  int          fails = 0, comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  trig_model u_trig (.clk_sys(clk_sys), .pins(pins));
  counter_latch_compare u_dut (.clk_sys(clk_sys), .srst(srst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .latch_pin(pins[0]),
    .origin_pin(pins[1]), .encoder_index_pin(pins[2]),
    .general_pin(pins[6:3]), .cmd_pulse_in(cmd), .cmd_pulse_dir(1'b0),
    .enc_step(enc), .enc_dir(1'b0), .cmd_pulse_out(pulse_out),
    .cmp_one_out_pin(cmp1), .cmp_two_out_pin(cmp2), .event_irq(irq));
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // request stands until the edge at which ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      test_done();
    end
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // command and encoder steps together; pulse pin checked in the burst's last cycle
  task automatic cnt(input int n, input logic p);
    @(posedge clk_sys) {cmd, enc} <= 2'b11;
    repeat (n - 1) @(posedge clk_sys);
    @(negedge clk_sys) chk({31'h0, pulse_out}, {31'h0, p});
    @(posedge clk_sys) {cmd, enc} <= 2'b00;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic trig(input int idx, input int w);
    u_trig.pulse(idx, w);
    repeat (60) @(posedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rd(capcmp_pkg::OFS_STATUS, 32'h0);
    rd(8'hFC, 32'h0);
    cnt(5, 1'b1);
    wb(1'b1, capcmp_pkg::OFS_COUNTER_ENV, 32'h4);
    cnt(5, 1'b1);
    rd(capcmp_pkg::OFS_COUNTER_ONE, 32'h5);
    rd(capcmp_pkg::OFS_COUNTER_TWO, 32'hA);
    wb(1'b1, capcmp_pkg::OFS_COUNTER_ENV, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_OPMODE, 32'h800);
    cnt(5, 1'b1);
    rd(capcmp_pkg::OFS_COUNTER_TWO, 32'hA);
    // counter one on encoder steps, counter two on command pulses
    wb(1'b1, capcmp_pkg::OFS_COUNTER_ENV, 32'h1_0000);
    wb(1'b1, capcmp_pkg::OFS_INPUT_ENV, 32'h4000);
    cnt(5, 1'b1);
    rd(capcmp_pkg::OFS_COUNTER_ONE, 32'h5);
    wb(1'b1, capcmp_pkg::OFS_INPUT_ENV, 32'h0);
    cnt(5, 1'b1);
    rd(capcmp_pkg::OFS_COUNTER_ONE, 32'hA);
    rd(capcmp_pkg::OFS_COUNTER_TWO, 32'hA);
    wb(1'b1, capcmp_pkg::OFS_OPMODE, 32'h47);
    cnt(5, 1'b1);
    rd(capcmp_pkg::OFS_COUNTER_ONE, 32'hF);
    rd(capcmp_pkg::OFS_COUNTER_TWO, 32'hA);
    wb(1'b1, capcmp_pkg::OFS_OPMODE, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_OUTPUT_ENV, 32'h8000_0000);
    cnt(5, 1'b0);
    rd(capcmp_pkg::OFS_COUNTER_TWO, 32'hF);
    wb(1'b1, capcmp_pkg::OFS_OUTPUT_ENV, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_COUNTER_ENV, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_COUNTER_ONE, 32'h1234);
    wb(1'b1, capcmp_pkg::OFS_COUNTER_TWO, 32'h5678);
    // cap3 latch pin rising first-only; cap4 origin falling every
    wb(1'b1, capcmp_pkg::OFS_LATCH_CFG, 32'h3209);
    trig(0, 40);
    rd(capcmp_pkg::OFS_STATUS, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_COMMAND, 32'h3C);
    wb(1'b1, capcmp_pkg::OFS_COMMAND, 32'h3D);
    wb(1'b1, capcmp_pkg::OFS_IRQ_EN, 32'h3_0000);
    rd(capcmp_pkg::OFS_STATUS, 32'h12_0000);
    trig(0, 40);
    rd(capcmp_pkg::OFS_STATUS, 32'h1E_0000);
    rd(capcmp_pkg::OFS_CAP3, 32'h1234);
    rd(capcmp_pkg::OFS_EVENT_FLAGS, 32'h1_0000);
    trig(0, 40);
    rd(capcmp_pkg::OFS_STATUS, 32'h1E_0000);
    trig(1, 40);
    rd(capcmp_pkg::OFS_STATUS, 32'h7E_0000);
    rd(capcmp_pkg::OFS_CAP4, 32'h5678);
    rd(capcmp_pkg::OFS_EVENT_FLAGS, 32'h3_0000);
    trig(1, 40);
    rd(capcmp_pkg::OFS_STATUS, 32'h3E_0000);
    // shorter than the filter width, so no capture
    trig(1, 10);
    rd(capcmp_pkg::OFS_STATUS, 32'h3E_0000);
    wb(1'b1, capcmp_pkg::OFS_COMMAND, 32'h3E);
    rd(capcmp_pkg::OFS_STATUS, 32'h30_0000);
    wb(1'b1, capcmp_pkg::OFS_COMMAND, 32'h3F);
    rd(capcmp_pkg::OFS_STATUS, 32'h0);
    wb(1'b1, capcmp_pkg::OFS_IRQ_EN, 32'h40);
    wb(1'b1, capcmp_pkg::OFS_EVENT_FLAGS, 32'hFFFF_FFFF);
    rd(capcmp_pkg::OFS_EVENT_FLAGS, 32'h0);
    @(negedge clk_sys) chk({31'h0, irq}, 32'h0);
    // compare values one below, equal to and one above the counters
    for (int d = -1; d < 2; d++) begin
      wb(1'b1, capcmp_pkg::OFS_CMP_ONE, 32'h1234 + 32'(d));
      wb(1'b1, capcmp_pkg::OFS_CMP_TWO, 32'h5678 + 32'(d));
      for (int i = 0; i < 4; i++) begin
        logic m;
        m = (i == 1 && d == 0) || (i == 2 && d > 0) || (i == 3 && d < 0);
        wb(1'b1, capcmp_pkg::OFS_COUNTER_ENV, 32'(i) << 12 | 32'(i) << 14);
        repeat (4) @(negedge clk_sys);
        chk({31'h0, cmp1}, {31'h0, m});
        chk({31'h0, cmp2}, {31'h0, m});
      end
    end
    rd(capcmp_pkg::OFS_EVENT_FLAGS, 32'h40);
    chk({31'h0, irq}, 32'h1);
    test_done();
  end
endmodule
